// ### hw/line_regs_pkg.sv
// Package of offsets, reset values and timing for the primary line register bank
`default_nettype none
package line_regs_pkg;
	localparam int CHANNELS = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFF_DEVICE_IDENTITY = 8'h00;
	localparam logic [7:0] OFF_ANALOG_LOOPBACK_CTRL = 8'h01;
	localparam logic [7:0] OFF_REMOTE_LOOPBACK_CTRL = 8'h02;
	localparam logic [7:0] OFF_SEND_ALL_ONES_CTRL = 8'h03;
	localparam logic [7:0] OFF_SIGNAL_ABSENT_STATUS = 8'h04;
	localparam logic [7:0] OFF_DRIVER_FAULT_STATUS = 8'h05;
	localparam logic [7:0] OFF_SIGNAL_ABSENT_IRQ_MASK = 8'h06;
	localparam logic [7:0] OFF_DRIVER_FAULT_IRQ_MASK = 8'h07;
	localparam logic [7:0] OFF_SIGNAL_ABSENT_IRQ_FLAG = 8'h08;
	localparam logic [7:0] OFF_DRIVER_FAULT_IRQ_FLAG = 8'h09;
	localparam logic [7:0] OFF_SOFTWARE_RESET = 8'h0A;
	localparam logic [7:0] OFF_MONITOR_POINT_CONFIG = 8'h0B;
	localparam logic [7:0] OFF_DIGITAL_LOOPBACK_CTRL = 8'h0C;
	localparam logic [7:0] OFF_ALARM_CRITERIA_SELECT = 8'h0D;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_SOFTWARE_RESET = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int MC_LSB = 0;
	localparam int MC_W = 4;
	localparam int MC_DIR_BIT = 3;
	localparam int CLK_MHZ = 100;
	localparam int SWRST_TIME_NS = 1000;
	localparam int SWRST_CYCLES = (SWRST_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SWRST_CNT_W = 8;
endpackage
`default_nettype wire

// ### hw/line_status_if.sv
// Interface carrying per-channel status and read-clear strobes to the event tracker
`default_nettype none
interface line_status_if #(parameter int CH = 8);
	logic [CH-1:0] status;
	logic [CH-1:0] mask;
	logic clear_rd;
	logic soft_rst;
	logic [CH-1:0] flag;
	modport bank (output status, output mask, output clear_rd, output soft_rst, input flag);
	modport tracker (input status, input mask, input clear_rd, input soft_rst, output flag);
endinterface
`default_nettype wire

// ### hw/line_event_tracker.sv
// Sticky transition flags for one per-channel status register
`default_nettype none
module line_event_tracker #(
	parameter int CH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	line_status_if.tracker st
);
	logic [CH-1:0] prev_q;
	logic [CH-1:0] flag_q;
	logic [CH-1:0] edge_set;

	// Any change of a status bit while its mask allows it
	assign edge_set = (st.status ^ prev_q) & st.mask;
	assign st.flag = flag_q;

	// Previous status, for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n || st.soft_rst) begin
			prev_q <= '0;
		end else begin
			prev_q <= st.status;
		end
	end

	// Set wins over the read clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n || st.soft_rst) begin
			flag_q <= '0;
		end else begin
			flag_q <= (flag_q & ~{CH{st.clear_rd}}) | edge_set;
		end
	end
endmodule
`default_nettype wire

// ### hw/line_soft_reset.sv
// Timed software reset pulse generator
`default_nettype none
module line_soft_reset #(
	parameter int CYCLES = line_regs_pkg::SWRST_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic active
);
	logic [line_regs_pkg::SWRST_CNT_W-1:0] cnt_q;

	// Count the reset window down from the start strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= (line_regs_pkg::SWRST_CNT_W)'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign active = (cnt_q != '0);
endmodule
`default_nettype wire

// ### hw/line_primary_regs.sv
// Primary control and status register bank of the octal line interface
`default_nettype none
module line_primary_regs #(
	parameter logic [7:0] IDENTITY_VALUE = 8'h5A, // Arbitrary identity value
	parameter int CH = line_regs_pkg::CHANNELS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [line_regs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [line_regs_pkg::DATA_W-1:0] reg_wdata,
	output logic [line_regs_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [CH-1:0] signal_absent_in,
	input wire logic [CH-1:0] driver_fault_in,
	input wire logic e1_mode,
	output logic [CH-1:0] analog_loopback_en,
	output logic [CH-1:0] remote_loopback_en,
	output logic [CH-1:0] send_all_ones_en,
	output logic [CH-1:0] digital_loopback_en,
	output logic [CH-1:0] etsi_criterion_sel,
	output logic monitor_enable,
	output logic monitor_transmit,
	output logic [2:0] monitor_channel,
	output logic soft_reset_busy
);
	// ****************************************
	// Pin synchronisers and state
	// ****************************************
	logic [CH-1:0] los_s1_q;
	logic [CH-1:0] los_s2_q;
	logic [CH-1:0] df_s1_q;
	logic [CH-1:0] df_s2_q;
	logic e1_s1_q;
	logic e1_s2_q;
	logic [CH-1:0] alb_q;
	logic [CH-1:0] rlb_q;
	logic [CH-1:0] tao_q;
	logic [CH-1:0] signal_absent_irq_mask_q;
	logic [CH-1:0] dfm_q;
	logic [CH-1:0] dlb_q;
	logic [CH-1:0] lac_q;
	logic [7:0] monitor_point_config_q;
	logic [7:0] swrst_q;
	logic swrst_start;
	logic swrst_active;
	logic bank_rst;
	logic [7:0] rdata_d;
	logic [3:0] mc;

	line_status_if #(.CH(CH)) los_if ();
	line_status_if #(.CH(CH)) df_if ();

	// Write strobe decode shared by all control registers
	// One decode form keeps every register's write hit alike
	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
		wr_hit = w && (a == off);
	endfunction

	// Signal-absent pins cross from the line side through two flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			los_s1_q <= '0;
			los_s2_q <= '0;
		end else begin
			los_s1_q <= signal_absent_in;
			los_s2_q <= los_s1_q;
		end
	end

	// Driver fault pins, same two-flop crossing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			df_s1_q <= '0;
			df_s2_q <= '0;
		end else begin
			df_s1_q <= driver_fault_in;
			df_s2_q <= df_s1_q;
		end
	end

	// Line standard select; only the second flop feeds the criterion pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			e1_s1_q <= 1'b0;
			e1_s2_q <= 1'b0;
		end else begin
			e1_s1_q <= e1_mode;
			e1_s2_q <= e1_s1_q;
		end
	end

	// ****************************************
	// Software reset
	// ****************************************
	// A write here restarts the window; bank writes inside it are dropped
	assign swrst_start = wr_hit(reg_addr, line_regs_pkg::OFF_SOFTWARE_RESET, reg_wr);
	assign bank_rst = !rst_n || swrst_active;

	line_soft_reset #(.CYCLES(line_regs_pkg::SWRST_CYCLES)) u_swrst (
		.clk(clk),
		.rst_n(rst_n),
		.start(swrst_start),
		.active(swrst_active)
	);

	// Write leaves the software reset register content unchanged
	// It reads back its fixed default; a write only starts the window
	always_ff @(posedge clk) begin
		if (bank_rst) begin
			swrst_q <= line_regs_pkg::RST_SOFTWARE_RESET;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Loopback and all-ones enables, bit n for channel n
	always_ff @(posedge clk) begin
		if (bank_rst) begin
			alb_q <= line_regs_pkg::RST_CTRL;
			rlb_q <= line_regs_pkg::RST_CTRL;
			tao_q <= line_regs_pkg::RST_CTRL;
			dlb_q <= line_regs_pkg::RST_CTRL;
		end else begin
			if (wr_hit(reg_addr, line_regs_pkg::OFF_ANALOG_LOOPBACK_CTRL, reg_wr)) begin
				alb_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, line_regs_pkg::OFF_REMOTE_LOOPBACK_CTRL, reg_wr)) begin
				rlb_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, line_regs_pkg::OFF_SEND_ALL_ONES_CTRL, reg_wr)) begin
				tao_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, line_regs_pkg::OFF_DIGITAL_LOOPBACK_CTRL, reg_wr)) begin
				dlb_q <= reg_wdata;
			end
		end
	end

	// Interrupt masks
	always_ff @(posedge clk) begin
		if (bank_rst) begin
			signal_absent_irq_mask_q <= line_regs_pkg::RST_CTRL;
			dfm_q <= line_regs_pkg::RST_CTRL;
		end else begin
			if (wr_hit(reg_addr, line_regs_pkg::OFF_SIGNAL_ABSENT_IRQ_MASK, reg_wr)) begin
				signal_absent_irq_mask_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, line_regs_pkg::OFF_DRIVER_FAULT_IRQ_MASK, reg_wr)) begin
				dfm_q <= reg_wdata;
			end
		end
	end

	// Monitor point and alarm criterion
	always_ff @(posedge clk) begin
		if (bank_rst) begin
			monitor_point_config_q <= line_regs_pkg::RST_CTRL;
			lac_q <= line_regs_pkg::RST_CTRL;
		end else begin
			if (wr_hit(reg_addr, line_regs_pkg::OFF_MONITOR_POINT_CONFIG, reg_wr)) begin
				monitor_point_config_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, line_regs_pkg::OFF_ALARM_CRITERIA_SELECT, reg_wr)) begin
				lac_q <= reg_wdata;
			end
		end
	end

	// ****************************************
	// Transition flags
	// ****************************************
	// Flags watch the synchronised status, so a pin pulse shorter than
	// a clock may be missed; a mask change alone never sets a flag
	assign los_if.status = los_s2_q;
	assign los_if.mask = signal_absent_irq_mask_q;
	assign los_if.clear_rd = reg_rd && (reg_addr == line_regs_pkg::OFF_SIGNAL_ABSENT_STATUS);
	assign los_if.soft_rst = swrst_active;
	assign df_if.status = df_s2_q;
	assign df_if.mask = dfm_q;
	assign df_if.clear_rd = reg_rd && (reg_addr == line_regs_pkg::OFF_DRIVER_FAULT_STATUS);
	assign df_if.soft_rst = swrst_active;

	line_event_tracker #(.CH(CH)) u_los_evt (
		.clk(clk),
		.rst_n(rst_n),
		.st(los_if.tracker)
	);

	line_event_tracker #(.CH(CH)) u_df_evt (
		.clk(clk),
		.rst_n(rst_n),
		.st(df_if.tracker)
	);

	// ****************************************
	// Read path
	// ****************************************
	// Registered read data, zero for unmapped offsets
	always_comb begin
		if (reg_addr == line_regs_pkg::OFF_DEVICE_IDENTITY) begin
			rdata_d = IDENTITY_VALUE;
		end else if (reg_addr == line_regs_pkg::OFF_ANALOG_LOOPBACK_CTRL) begin
			rdata_d = alb_q;
		end else if (reg_addr == line_regs_pkg::OFF_REMOTE_LOOPBACK_CTRL) begin
			rdata_d = rlb_q;
		end else if (reg_addr == line_regs_pkg::OFF_SEND_ALL_ONES_CTRL) begin
			rdata_d = tao_q;
		end else if (reg_addr == line_regs_pkg::OFF_SIGNAL_ABSENT_STATUS) begin
			rdata_d = los_s2_q;
		end else if (reg_addr == line_regs_pkg::OFF_DRIVER_FAULT_STATUS) begin
			rdata_d = df_s2_q;
		end else if (reg_addr == line_regs_pkg::OFF_SIGNAL_ABSENT_IRQ_MASK) begin
			rdata_d = signal_absent_irq_mask_q;
		end else if (reg_addr == line_regs_pkg::OFF_DRIVER_FAULT_IRQ_MASK) begin
			rdata_d = dfm_q;
		end else if (reg_addr == line_regs_pkg::OFF_SIGNAL_ABSENT_IRQ_FLAG) begin
			rdata_d = los_if.flag;
		end else if (reg_addr == line_regs_pkg::OFF_DRIVER_FAULT_IRQ_FLAG) begin
			rdata_d = df_if.flag;
		end else if (reg_addr == line_regs_pkg::OFF_SOFTWARE_RESET) begin
			rdata_d = swrst_q;
		end else if (reg_addr == line_regs_pkg::OFF_MONITOR_POINT_CONFIG) begin
			rdata_d = monitor_point_config_q;
		end else if (reg_addr == line_regs_pkg::OFF_DIGITAL_LOOPBACK_CTRL) begin
			rdata_d = dlb_q;
		end else if (reg_addr == line_regs_pkg::OFF_ALARM_CRITERIA_SELECT) begin
			rdata_d = lac_q;
		end else begin
			rdata_d = line_regs_pkg::READ_UNMAPPED;
		end
	end

	// Read data updates only on a read strobe
	// Soft reset leaves it alone, so the last read stays visible
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// ****************************************
	// Registered control outputs
	// ****************************************
	// Upper nibble of the monitor register is stored but drives nothing
	assign mc = monitor_point_config_q[line_regs_pkg::MC_LSB +: line_regs_pkg::MC_W];

	// Loopback and all-ones pins follow their registers one cycle later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			analog_loopback_en <= '0;
			remote_loopback_en <= '0;
			send_all_ones_en <= '0;
			digital_loopback_en <= '0;
		end else begin
			analog_loopback_en <= alb_q;
			remote_loopback_en <= rlb_q;
			send_all_ones_en <= tao_q;
			digital_loopback_en <= dlb_q;
		end
	end

	// Criterion and monitor pins; T1 forces the criterion bits low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			etsi_criterion_sel <= '0;
			monitor_enable <= 1'b0;
			monitor_transmit <= 1'b0;
			monitor_channel <= 3'h0;
		end else begin
			etsi_criterion_sel <= lac_q & {CH{e1_s2_q}};
			monitor_enable <= (mc[2:0] != 3'h0);
			monitor_transmit <= mc[line_regs_pkg::MC_DIR_BIT];
			monitor_channel <= mc[2:0];
		end
	end

	// Busy flag lags the reset window by one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_reset_busy <= 1'b0;
		end else begin
			soft_reset_busy <= swrst_active;
		end
	end
endmodule
`default_nettype wire

// ### sim/line_primary_regs_chk.sv
// Port checks of the primary line register bank
`default_nettype none
module line_primary_regs_chk #(
	parameter logic [7:0] IDENTITY_VALUE = 8'h5A, // Arbitrary identity value
	parameter int CH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [CH-1:0] signal_absent_in,
	input wire logic [CH-1:0] driver_fault_in,
	input wire logic e1_mode,
	input wire logic [CH-1:0] analog_loopback_en,
	input wire logic [CH-1:0] remote_loopback_en,
	input wire logic [CH-1:0] send_all_ones_en,
	input wire logic [CH-1:0] digital_loopback_en,
	input wire logic [CH-1:0] etsi_criterion_sel,
	input wire logic monitor_enable,
	input wire logic monitor_transmit,
	input wire logic [2:0] monitor_channel,
	input wire logic soft_reset_busy
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic swr_q;
	logic wr_ok;
	logic [7:0] busy_cnt_q;
	// Soft reset write of last cycle, before the busy flag shows it
	always_ff @(posedge clk) begin
		swr_q <= rst_n && reg_wr && reg_addr == 8'h0A;
	end
	// Length of the running soft reset window
	always_ff @(posedge clk) begin
		if (!rst_n || !soft_reset_busy) begin
			busy_cnt_q <= 8'h00;
		end else begin
			busy_cnt_q <= busy_cnt_q + 8'h01;
		end
	end
	assign wr_ok = reg_wr && !soft_reset_busy && !swr_q;
	a_analog_pin: assert property (wr_ok && reg_addr == 8'h01 |->
		##2 analog_loopback_en == $past(reg_wdata, 2)) else $error("analog pin wrong");
	a_digital_pin: assert property (wr_ok && reg_addr == 8'h0C |->
		##2 digital_loopback_en == $past(reg_wdata, 2)) else $error("digital pin wrong");
	a_monitor_decode: assert property (wr_ok && reg_addr == 8'h0B |-> ##2
		{monitor_enable, monitor_transmit, monitor_channel} ==
		{$past(reg_wdata[2:0], 2) != 3'h0, $past(reg_wdata[3:0], 2)}) else $error("monitor wrong");
	a_identity_read: assert property (reg_rd && reg_addr == 8'h00 |=>
		reg_rdata == IDENTITY_VALUE) else $error("identity wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h0D |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	a_reset_starts: assert property (wr_ok && reg_addr == 8'h0A |->
		##2 soft_reset_busy [*8]) else $error("soft reset not started");
	a_reset_length: assert property ($fell(soft_reset_busy) |->
		busy_cnt_q == 8'(line_regs_pkg::SWRST_CYCLES)) else $error("soft reset length wrong");
	a_reset_clears: assert property (soft_reset_busy && $past(soft_reset_busy) |->
		(analog_loopback_en | remote_loopback_en | send_all_ones_en | digital_loopback_en |
		etsi_criterion_sel) == '0 && !monitor_enable) else $error("pins set in soft reset");
	a_t1_criterion: assert property (!e1_mode [*4] |=> etsi_criterion_sel == '0)
		else $error("criterion set in T1");
	c_soft_reset: cover property (reg_wr && reg_addr == 8'h0A);
	c_flag_read: cover property (reg_rd && reg_addr == 8'h08 ##1 reg_rdata != 8'h00);
	c_monitor_tx: cover property (monitor_enable && monitor_transmit);
endmodule
`default_nettype wire

// ### sim/line_primary_regs_tb_top.sv
// Self-checking bench of the primary line register bank
`default_nettype none
module line_primary_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ID_VAL = 8'hA7; // Arbitrary identity value
	logic clk, rst_n, reg_wr, reg_rd, e1_mode, monitor_enable, monitor_transmit, soft_reset_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, signal_absent_in, driver_fault_in;
	logic [7:0] analog_loopback_en, remote_loopback_en, send_all_ones_en, digital_loopback_en;
	logic [7:0] etsi_criterion_sel, d, m1, m2, p1, p2;
	logic [2:0] monitor_channel;
	logic [7:0] ro_off [7] = '{8'h00, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0E, 8'hFF};
	logic [7:0] rw_off [7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0C, 8'h0D};
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	line_primary_regs #(.IDENTITY_VALUE(ID_VAL)) i_line_primary_regs (.clk, .rst_n, .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .signal_absent_in, .driver_fault_in, .e1_mode,
		.analog_loopback_en, .remote_loopback_en, .send_all_ones_en, .digital_loopback_en,
		.etsi_criterion_sel, .monitor_enable, .monitor_transmit, .monitor_channel,
		.soft_reset_busy);
	// Clock of 10 ns
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end
	function automatic logic [7:0] exp_rst(input logic [7:0] a);
		return (a == 8'h00) ? ID_VAL : (a == 8'h0A) ? 8'hFF : 8'h00;
	endfunction
	function automatic logic [7:0] exp_mon(input logic [3:0] c);
		return {3'h0, c[2:0] != 3'h0, c};
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		chk(nm, reg_rdata, e);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, e1_mode, reg_addr, reg_wdata} = '0;
		{signal_absent_in, driver_fault_in} = '0;
		d = 8'($urandom(26336));
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int a = 0; a < 14; a++) begin
			rchk("reset_value", 8'(a), exp_rst(8'(a)));
		end
		foreach (ro_off[i]) begin
			wr(ro_off[i], 8'hFF);
			rchk("read_only", ro_off[i], exp_rst(ro_off[i]));
		end
		$display("test map done");
		for (int r = 0; r < 4; r++) begin
			e1_mode = !r[0];
			foreach (rw_off[i]) begin
				d = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : 8'($urandom);
				wr(rw_off[i], d);
				rchk("read_back", rw_off[i], d);
				case (rw_off[i])
					8'h01: chk("analog_pin", analog_loopback_en, d);
					8'h02: chk("remote_pin", remote_loopback_en, d);
					8'h03: chk("ones_pin", send_all_ones_en, d);
					8'h0C: chk("digital_pin", digital_loopback_en, d);
					8'h0D: chk("criterion_pin", etsi_criterion_sel, e1_mode ? d : 8'h00);
					default: ;
				endcase
			end
		end
		for (int c = 0; c < 16; c++) begin
			wr(8'h0B, 8'(c));
			rchk("monitor_code", 8'h0B, 8'(c));
			d = {3'h0, monitor_enable, monitor_transmit, monitor_channel};
			chk("monitor_pins", d, exp_mon(4'(c)));
		end
		$display("test controls done");
		{p1, p2} = '0;
		for (int k = 0; k < 6; k++) begin
			{m1, m2} = 16'($urandom);
			wr(8'h06, m1);
			wr(8'h07, m2);
			signal_absent_in = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			driver_fault_in = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			repeat (6) @(posedge clk);
			rchk("absent_flag", 8'h08, (signal_absent_in ^ p1) & m1);
			rchk("fault_flag", 8'h09, (driver_fault_in ^ p2) & m2);
			rchk("absent_status", 8'h04, signal_absent_in);
			rchk("fault_status", 8'h05, driver_fault_in);
			rchk("absent_clear", 8'h08, 8'h00);
			rchk("fault_clear", 8'h09, 8'h00);
			{p1, p2} = {signal_absent_in, driver_fault_in};
		end
		$display("test events done");
		{signal_absent_in, driver_fault_in} = '0;
		wr(8'h01, 8'hFF);
		wr(8'h0B, 8'h0F);
		wr(8'h0A, 8'($urandom));
		wr(8'h0C, 8'hFF);
		@(posedge clk);
		#1;
		chk("busy", {7'h00, soft_reset_busy}, 8'h01);
		n = 0;
		while (soft_reset_busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("busy_end", {7'h00, soft_reset_busy}, 8'h00);
		chk("busy_cycles", 8'(n), 8'(line_regs_pkg::SWRST_CYCLES - 2));
		for (int a = 0; a < 14; a++) begin
			rchk("soft_reset_value", 8'(a), exp_rst(8'(a)));
		end
		chk("soft_reset_pins", analog_loopback_en | digital_loopback_en, 8'h00);
		$display("test soft reset done");
		wrap_up();
	end
endmodule
bind line_primary_regs line_primary_regs_chk #(.IDENTITY_VALUE(IDENTITY_VALUE), .CH(CH))
	i_line_primary_regs_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.signal_absent_in, .driver_fault_in, .e1_mode, .analog_loopback_en, .remote_loopback_en,
	.send_all_ones_en, .digital_loopback_en, .etsi_criterion_sel, .monitor_enable,
	.monitor_transmit, .monitor_channel, .soft_reset_busy);
`default_nettype wire
